/* File: verilog/uvio_pkg.sv */
// uvio_pkg: constants and types for the virtual i/o pin block.
// assumes one 200 MHz clock; usb state and buffer levels come from neighbouring blocks.
package uvio_pkg;
  localparam int unsigned NUM_PINS = 11;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned IND_TIME_MS = 100;
  localparam int unsigned IND_CYCLES = IND_TIME_MS * 1000 * CLK_MHZ;
  localparam int unsigned BUF_DEPTH = 128;
  localparam logic [7:0] RX_SPACE_LOW = 8'h10;
  localparam logic [7:0] RX_SPACE_HIGH = 8'h20;
  localparam logic [6:0] SEND_BATCH = 7'h3f;
  localparam int unsigned SEND_PIN = 9;
  localparam int unsigned INT_PIN = 9;
  localparam int unsigned RESET_PIN = 0;
  localparam int unsigned ANALOG_PIN_LARGE = 1;
  localparam int unsigned ANALOG_PIN_SMALL = 3;

  typedef enum logic [4:0] {
    UVIO_FN_NONE = 5'h00,
    UVIO_FN_RESET = 5'h01,
    UVIO_FN_SELF_PWR = 5'h02,
    UVIO_FN_TX_IND = 5'h03,
    UVIO_FN_RX_IND = 5'h04,
    UVIO_FN_TXRX_IND = 5'h05,
    UVIO_FN_CONFIGURED = 5'h06,
    UVIO_FN_SUSPEND_N = 5'h07,
    UVIO_FN_HOST_RDY = 5'h08,
    UVIO_FN_LOW_PWR = 5'h09,
    UVIO_FN_ALL_GO_N = 5'h0a,
    UVIO_FN_RX_NOT_FULL = 5'h0b,
    UVIO_FN_TX_EMPTY = 5'h0c,
    UVIO_FN_SEND = 5'h0d,
    UVIO_FN_DIG_IN = 5'h0e,
    UVIO_FN_DIG_OUT = 5'h0f,
    UVIO_FN_INTERRUPT = 5'h10,
    UVIO_FN_ANALOG = 5'h11
  } uvio_fn_t;

  typedef enum logic [3:0] {
    UVIO_ST_INIT = 4'h1,
    UVIO_ST_READY = 4'h2,
    UVIO_ST_APP = 4'h4,
    UVIO_ST_SLEEP = 4'h8
  } uvio_usb_st_t;

  typedef struct packed {
    uvio_usb_st_t state;
    logic hub_powered;
  } uvio_usb_t;

  typedef struct packed {
    logic configured;
    logic suspend_n;
    logic low_pwr;
    logic all_go_n;
    logic host_rdy;
  } uvio_status_t;

  localparam logic [31:0] IND_CNT_ZERO = 32'h0;
endpackage

/* File: verilog/uvio_pins.sv */
// uvio_pins: virtual i/o pin function mux, usb status, indicators and flow flags.
// assumes usb state, buffer events and pin functions arrive synchronous to ref_clk_i.
`timescale 1ns/10ps
`default_nettype none
module uvio_pins (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [54:0] pin_fn_i,
  input wire logic small_pkg_i,
  input wire uvio_pkg::uvio_usb_t usb_i,
  input wire logic tx_to_host_i,
  input wire logic rx_from_host_i,
  input wire logic [7:0] rx_space_i,
  input wire logic rx_byte_i,
  input wire logic i2c_stop_i,
  input wire logic tx_push_i,
  input wire logic tx_last_start_i,
  input wire logic tx_buf_empty_i,
  input wire logic [10:0] pin_wr_data_i,
  input wire logic pin_wr_i,
  input wire logic [10:0] vio_in_i,
  output logic [10:0] vio_out_o,
  output logic [10:0] vio_oe_o,
  output logic [10:0] pin_rd_o,
  output logic self_pwr_o,
  output logic rx_store_o,
  output logic forward_o,
  output logic send_irq_o,
  output logic int_evt_o,
  output logic pin_reset_o,
  output logic analog_sel_o,
  output logic [3:0] analog_pin_o
);
  uvio_pkg::uvio_fn_t fn [uvio_pkg::NUM_PINS];
  uvio_pkg::uvio_status_t status;
  logic [31:0] tx_cnt_reg;
  logic [31:0] rx_cnt_reg;
  logic [31:0] trx_cnt_reg;
  logic rx_nf_reg;
  logic tx_empty_reg;
  logic [10:0] dout_reg;
  logic [6:0] held_reg;
  logic send_prev_reg;
  logic int_prev_reg;
  logic send_lvl;
  logic int_lvl;

  always_comb begin
    for (int i = 0; i < uvio_pkg::NUM_PINS; i++) begin
      fn[i] = uvio_pkg::uvio_fn_t'(pin_fn_i[i*5 +: 5]);
    end
  end

  always_comb begin
    status.configured = (usb_i.state != uvio_pkg::UVIO_ST_INIT);
    status.suspend_n = (usb_i.state != uvio_pkg::UVIO_ST_SLEEP);
    status.low_pwr = (usb_i.state == uvio_pkg::UVIO_ST_INIT) ||
                     (usb_i.state == uvio_pkg::UVIO_ST_SLEEP) || !usb_i.hub_powered;
    status.all_go_n = !(status.configured && status.suspend_n);
    status.host_rdy = (usb_i.state == uvio_pkg::UVIO_ST_APP);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_cnt_reg <= uvio_pkg::IND_CNT_ZERO;
    end else if (tx_to_host_i) begin
      tx_cnt_reg <= 32'(uvio_pkg::IND_CYCLES);
    end else if (tx_cnt_reg != uvio_pkg::IND_CNT_ZERO) begin
      tx_cnt_reg <= tx_cnt_reg - 32'h1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_cnt_reg <= uvio_pkg::IND_CNT_ZERO;
    end else if (rx_from_host_i) begin
      rx_cnt_reg <= 32'(uvio_pkg::IND_CYCLES);
    end else if (rx_cnt_reg != uvio_pkg::IND_CNT_ZERO) begin
      rx_cnt_reg <= rx_cnt_reg - 32'h1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trx_cnt_reg <= uvio_pkg::IND_CNT_ZERO;
    end else if (tx_to_host_i || rx_from_host_i) begin
      trx_cnt_reg <= 32'(uvio_pkg::IND_CYCLES);
    end else if (trx_cnt_reg != uvio_pkg::IND_CNT_ZERO) begin
      trx_cnt_reg <= trx_cnt_reg - 32'h1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_nf_reg <= 1'b1;
    end else if (rx_space_i <= uvio_pkg::RX_SPACE_LOW) begin
      rx_nf_reg <= 1'b0;
    end else if (rx_space_i >= uvio_pkg::RX_SPACE_HIGH) begin
      rx_nf_reg <= 1'b1;
    end
  end

  // store only with space; flag is advisory
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_store_o <= 1'b0;
    end else begin
      rx_store_o <= rx_byte_i && (rx_space_i != 8'h00);
    end
  end

  // tx empty: push wins over the last byte leaving
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_empty_reg <= 1'b1;
    end else if (tx_push_i) begin
      tx_empty_reg <= 1'b0;
    end else if (tx_last_start_i && tx_buf_empty_i) begin
      tx_empty_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dout_reg <= 11'h000;
    end else if (pin_wr_i) begin
      dout_reg <= pin_wr_data_i;
    end
  end

  assign send_lvl = (fn[uvio_pkg::SEND_PIN] == uvio_pkg::UVIO_FN_SEND) && vio_in_i[uvio_pkg::SEND_PIN];
  assign int_lvl = (fn[uvio_pkg::INT_PIN] == uvio_pkg::UVIO_FN_INTERRUPT) && vio_in_i[uvio_pkg::INT_PIN];

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      held_reg <= 7'h00;
    end else if (forward_o) begin
      held_reg <= {6'h00, rx_store_o};
    end else if (rx_store_o && held_reg != 7'h7f) begin
      held_reg <= held_reg + 7'h01;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      send_prev_reg <= 1'b0;
      send_irq_o <= 1'b0;
      forward_o <= 1'b0;
    end else begin
      send_prev_reg <= send_lvl;
      send_irq_o <= send_lvl && !send_prev_reg;
      // forward on send start, batch or stop while send active
      forward_o <= send_lvl && !forward_o &&
                   (!send_prev_reg || held_reg >= uvio_pkg::SEND_BATCH || i2c_stop_i);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_prev_reg <= 1'b0;
      int_evt_o <= 1'b0;
    end else begin
      int_prev_reg <= int_lvl;
      int_evt_o <= int_lvl && !int_prev_reg;
    end
  end

  // pin drive and readback, all registered
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vio_out_o <= 11'h000;
      vio_oe_o <= 11'h000;
      pin_rd_o <= 11'h000;
      self_pwr_o <= 1'b0;
      pin_reset_o <= 1'b0;
      analog_sel_o <= 1'b0;
      analog_pin_o <= 4'h0;
    end else begin
      self_pwr_o <= 1'b0;
      analog_sel_o <= 1'b0;
      analog_pin_o <= 4'h0;
      pin_reset_o <= (fn[uvio_pkg::RESET_PIN] == uvio_pkg::UVIO_FN_RESET) && !vio_in_i[uvio_pkg::RESET_PIN];
      for (int i = 0; i < uvio_pkg::NUM_PINS; i++) begin
        logic drv;
        logic val;
        drv = 1'b1;
        val = 1'b0;
        // no function and other inputs default to undriven
        unique case (fn[i])
          // indicators include the live event so the pin answers one cycle after it
          uvio_pkg::UVIO_FN_TX_IND: val = tx_to_host_i || (tx_cnt_reg != uvio_pkg::IND_CNT_ZERO);
          uvio_pkg::UVIO_FN_RX_IND: val = rx_from_host_i || (rx_cnt_reg != uvio_pkg::IND_CNT_ZERO);
          uvio_pkg::UVIO_FN_TXRX_IND: val = tx_to_host_i || rx_from_host_i ||
                                            (trx_cnt_reg != uvio_pkg::IND_CNT_ZERO);
          uvio_pkg::UVIO_FN_CONFIGURED: val = status.configured;
          uvio_pkg::UVIO_FN_SUSPEND_N: val = status.suspend_n;
          uvio_pkg::UVIO_FN_HOST_RDY: val = status.host_rdy;
          uvio_pkg::UVIO_FN_LOW_PWR: val = status.low_pwr;
          uvio_pkg::UVIO_FN_ALL_GO_N: val = status.all_go_n;
          uvio_pkg::UVIO_FN_RX_NOT_FULL: val = rx_nf_reg;
          // next value of the flag, so a push shows on the pin one cycle later
          uvio_pkg::UVIO_FN_TX_EMPTY: val = !tx_push_i && (tx_empty_reg || (tx_last_start_i && tx_buf_empty_i));
          uvio_pkg::UVIO_FN_DIG_OUT: val = dout_reg[i];
          default: drv = 1'b0;
        endcase
        if (i == uvio_pkg::RESET_PIN) begin
          drv = 1'b0;
        end
        vio_oe_o[i] <= drv;
        vio_out_o[i] <= drv & val;
        if (fn[i] == uvio_pkg::UVIO_FN_DIG_OUT) begin
          pin_rd_o[i] <= dout_reg[i];
        end else begin
          pin_rd_o[i] <= vio_in_i[i];
        end
        if (fn[i] == uvio_pkg::UVIO_FN_SELF_PWR && vio_in_i[i]) begin
          self_pwr_o <= 1'b1;
        end
        if (fn[i] == uvio_pkg::UVIO_FN_ANALOG &&
            i == (small_pkg_i ? uvio_pkg::ANALOG_PIN_SMALL : uvio_pkg::ANALOG_PIN_LARGE)) begin
          analog_sel_o <= 1'b1;
          analog_pin_o <= 4'(i);
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/uvio_pins_props.sv */
// uvio_pins_props: port-level checks of the virtual pin block.
// assumes one clock; outputs answer one cycle after their cause.
`timescale 1ns/10ps
`default_nettype none
module uvio_pins_props (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [54:0] pin_fn_i,
  input wire uvio_pkg::uvio_usb_t usb_i,
  input wire logic tx_to_host_i,
  input wire logic [7:0] rx_space_i,
  input wire logic rx_byte_i,
  input wire logic tx_push_i,
  input wire logic [10:0] vio_out_o,
  input wire logic [10:0] vio_oe_o,
  input wire logic rx_store_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [4:0] f4;
  logic ini;
  logic slp;
  assign f4 = pin_fn_i[24:20];
  assign ini = usb_i.state == uvio_pkg::UVIO_ST_INIT;
  assign slp = usb_i.state == uvio_pkg::UVIO_ST_SLEEP;
  // the $past(rst_n_i) guard skips the first edge after reset, where outputs still hold zero
  property p_cfg;
    $past(rst_n_i) && $past(f4) == uvio_pkg::UVIO_FN_CONFIGURED |-> vio_out_o[4] == !$past(ini);
  endproperty
  a_cfg: assert property (p_cfg) else $error("configured");
  property p_sus;
    $past(rst_n_i) && $past(f4) == uvio_pkg::UVIO_FN_SUSPEND_N |-> vio_out_o[4] == !$past(slp);
  endproperty
  a_sus: assert property (p_sus) else $error("suspend");
  property p_rdy;
    $past(rst_n_i) && $past(f4) == uvio_pkg::UVIO_FN_HOST_RDY |->
      vio_out_o[4] == $past(usb_i.state == uvio_pkg::UVIO_ST_APP);
  endproperty
  a_rdy: assert property (p_rdy) else $error("host ready");
  property p_lowp;
    $past(rst_n_i) && $past(f4) == uvio_pkg::UVIO_FN_LOW_PWR |->
      vio_out_o[4] == $past(ini || slp || !usb_i.hub_powered);
  endproperty
  a_lowp: assert property (p_lowp) else $error("low power");
  property p_go;
    $past(rst_n_i) && $past(f4) == uvio_pkg::UVIO_FN_ALL_GO_N |-> vio_out_o[4] == $past(ini || slp);
  endproperty
  a_go: assert property (p_go) else $error("all go");
  property p_pin0;
    $past(pin_fn_i[4:0]) == uvio_pkg::UVIO_FN_TX_IND |-> !vio_oe_o[0];
  endproperty
  a_pin0: assert property (p_pin0) else $error("pin 0 driven");
  property p_store;
    $past(rst_n_i) |-> rx_store_o == $past(rx_byte_i && rx_space_i != 8'h00);
  endproperty
  a_store: assert property (p_store) else $error("rx store");
  property p_txind;
    tx_to_host_i && f4 == uvio_pkg::UVIO_FN_TX_IND |=> vio_out_o[4] && vio_oe_o[4];
  endproperty
  a_txind: assert property (p_txind) else $error("tx indicator");
  property p_txe;
    tx_push_i && f4 == uvio_pkg::UVIO_FN_TX_EMPTY |=> !vio_out_o[4];
  endproperty
  a_txe: assert property (p_txe) else $error("tx empty");
endmodule
bind uvio_pins uvio_pins_props uvio_pins_props_i (.*);
`default_nettype wire

/* File: test/uvio_mcu.sv */
// uvio_mcu: far side of the pins, a controller with switches on each line.
// assumes the bench sets what the controller drives on undriven pins.
`timescale 1ns/10ps
`default_nettype none
module uvio_mcu (
  input wire logic [10:0] vio_out_i,
  input wire logic [10:0] vio_oe_i,
  input wire logic [10:0] drv_i,
  output logic [10:0] lvl_o
);
  // send or interrupt wired to pin 9
  assign lvl_o = (vio_oe_i & vio_out_i) | (~vio_oe_i & drv_i);
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// tb_top: directed tests of the virtual pin block at its plain ports.
// assumes a one-cycle answer; indicator off-time is too long to run.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic ref_clk_i = 0, rst_n_i = 0, small_pkg_i = 0, tx_buf_empty_i = 1, pin_wr_i = 0;
  logic tx_to_host_i = 0, rx_from_host_i = 0, rx_byte_i = 0, i2c_stop_i = 0, tx_push_i = 0;
  logic tx_last_start_i = 0, self_pwr_o, rx_store_o, forward_o, send_irq_o, int_evt_o;
  logic pin_reset_o, analog_sel_o;
  logic [54:0] pin_fn_i = '0;
  logic [10:0] pin_wr_data_i = '0, drv = '0, vio_in_i, vio_out_o, vio_oe_o, pin_rd_o;
  logic [7:0] rx_space_i = 8'h40;
  logic [3:0] analog_pin_o;
  uvio_pkg::uvio_usb_t usb_i = '{uvio_pkg::UVIO_ST_INIT, 1'b1};
  int errors = 0, n_compared = 0;
  logic [5:0] tbl [5] = '{6'h1f, 6'h3e, 6'h06, 6'h35, 6'h21};
  logic [3:0] sts [6] = '{4'h1, 4'h2, 4'h2, 4'h4, 4'h4, 4'h8};
  logic [5:0] hubs = 6'h2b;
  logic [7:0] spc [5] = '{8'h40, 8'h10, 8'h00, 8'h1f, 8'h20};
  logic [1:0] ex [5] = '{2'h3, 2'h2, 2'h0, 2'h2, 2'h3};
  initial forever #2.5 ref_clk_i = ~ref_clk_i;
  uvio_pins uvio_pins_i (.*);
  uvio_mcu uvio_mcu_i (.vio_out_i(vio_out_o), .vio_oe_i(vio_oe_o), .drv_i(drv), .lvl_o(vio_in_i));
  task automatic chk(input logic [10:0] s, input logic [10:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic ck();
    @(posedge ref_clk_i);
  endtask
  task automatic lv();
    ck();
    #1;
  endtask
  task automatic fn(input int p, input uvio_pkg::uvio_fn_t f);
    pin_fn_i[5*p+:5] <= f;
  endtask
  // one-cycle event pulse; order tx, rx, byte, stop, push, last, write
  task automatic ev(input logic [6:0] m);
    ck();
    {tx_to_host_i, rx_from_host_i, rx_byte_i, i2c_stop_i, tx_push_i, tx_last_start_i, pin_wr_i} <= m;
    ck();
    {tx_to_host_i, rx_from_host_i, rx_byte_i, i2c_stop_i, tx_push_i, tx_last_start_i, pin_wr_i} <= 7'h00;
    #1;
  endtask
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #20000;
    errors++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end
  initial begin
    repeat (10) ck();
    rst_n_i <= 1'b1;
    for (int f = 0; f < 5; f++) begin
      for (int c = 0; c < 6; c++) begin
        ck();
        fn(4, uvio_pkg::uvio_fn_t'(5'(6 + f)));
        usb_i <= '{uvio_pkg::uvio_usb_st_t'(sts[c]), hubs[5-c]};
        lv();
        chk({vio_oe_o[4], vio_out_o[4]}, {1'b1, tbl[f][5-c]});
      end
    end
    ck();
    fn(4, uvio_pkg::UVIO_FN_SELF_PWR);
    drv[4] <= 1'b1;
    lv();
    chk({self_pwr_o, vio_oe_o[4]}, 2'b10);
    $display("status test done");
    ck();
    fn(0, uvio_pkg::UVIO_FN_TX_IND);
    fn(1, uvio_pkg::UVIO_FN_RX_IND);
    fn(3, uvio_pkg::UVIO_FN_TXRX_IND);
    fn(4, uvio_pkg::UVIO_FN_TX_IND);
    ev(7'h40);
    chk(vio_out_o & vio_oe_o & 11'h01f, 11'h018);
    ev(7'h20);
    chk(vio_out_o & vio_oe_o & 11'h01f, 11'h01a);
    $display("indicator test done");
    fn(5, uvio_pkg::UVIO_FN_RX_NOT_FULL);
    for (int i = 0; i < 5; i++) begin
      ck();
      rx_space_i <= spc[i];
      ev(7'h10);
      chk({rx_store_o, vio_out_o[5]}, ex[i]);
    end
    $display("receive test done");
    ck();
    fn(4, uvio_pkg::UVIO_FN_TX_EMPTY);
    tx_buf_empty_i <= 1'b0;
    ev(7'h04);
    chk(vio_out_o[4], 1'b0);
    ev(7'h02);
    chk(vio_out_o[4], 1'b0);
    tx_buf_empty_i <= 1'b1;
    ev(7'h02);
    chk(vio_out_o[4], 1'b1);
    $display("transmit test done");
    ck();
    fn(9, uvio_pkg::UVIO_FN_SEND);
    ev(7'h08);
    chk({send_irq_o, forward_o}, 2'b00);
    ck();
    drv[9] <= 1'b1;
    lv();
    chk({send_irq_o, forward_o}, 2'b11);
    ev(7'h08);
    chk(forward_o, 1'b1);
    for (int i = 1; i <= 63; i++) begin
      ev(7'h10);
      chk(forward_o, 1'b0);
    end
    // byte to store pulse to count to forward takes two more edges
    ck();
    lv();
    chk(forward_o, 1'b1);
    ck();
    fn(9, uvio_pkg::UVIO_FN_INTERRUPT);
    drv[9] <= 1'b0;
    lv();
    ck();
    drv[9] <= 1'b1;
    lv();
    chk({int_evt_o, pin_rd_o[9]}, 2'b11);
    $display("send test done");
    ck();
    fn(7, uvio_pkg::UVIO_FN_DIG_OUT);
    fn(8, uvio_pkg::UVIO_FN_DIG_IN);
    drv[8] <= 1'b1;
    pin_wr_data_i <= 11'h080;
    lv();
    chk(vio_out_o[7], 1'b0);
    ev(7'h01);
    lv();
    chk({vio_out_o[7], vio_oe_o[7], pin_rd_o[7], pin_rd_o[8]}, 4'hf);
    ck();
    fn(0, uvio_pkg::UVIO_FN_RESET);
    fn(1, uvio_pkg::UVIO_FN_ANALOG);
    lv();
    chk({pin_reset_o, analog_sel_o, analog_pin_o}, 6'h31);
    $display("pin test done");
    end_sim();
  end
endmodule
`default_nettype wire
